// ===== rtl/cupw_cfg.svh
// Purpose: Constants for the compare unit PWM generator
// Assumes: 32-bit APB data, one word per register
// Notes:   Offsets are byte addresses
`ifndef CUPW_CFG_SVH
`define CUPW_CFG_SVH
`define CUPW_AW          8
`define CUPW_OFS_TMRCTL  8'h00
`define CUPW_OFS_PERIOD  8'h04
`define CUPW_OFS_CMP1    8'h08
`define CUPW_OFS_CMP2    8'h0C
`define CUPW_OFS_CMP3    8'h10
`define CUPW_OFS_ACTION  8'h14
`define CUPW_OFS_DBCTL   8'h18
`define CUPW_OFS_CMPCTL  8'h1C
`define CUPW_OFS_COUNT   8'h20
`define CUPW_OFS_STATUS  8'h24
`define CUPW_MODE_STOP   2'h0
`define CUPW_MODE_UP     2'h1
`define CUPW_MODE_UPDN   2'h2
`define CUPW_DB_M_HI     11
`define CUPW_DB_M_LO     8
`define CUPW_DB_EN_LO    5
`define CUPW_DB_PS_HI    4
`define CUPW_DB_PS_LO    2
`define CUPW_DB_MASK     16'h0FFC
`define CUPW_PS_MAX      3'h5
`define CUPW_CC_CMP_EN   15
`define CUPW_CC_OUT_EN   9
`define CUPW_CC_PROT_EN  0
`define CUPW_ACT_FLO     2'h0
`define CUPW_ACT_ALO     2'h1
`define CUPW_ACT_AHI     2'h2
`define CUPW_ACT_FHI     2'h3
`define CUPW_RST16       16'h0000
`define CUPW_RST9        9'h000
`endif

// ===== rtl/cupw_pkg.sv
// Purpose: Types for the compare unit PWM generator
// Assumes: Used with cupw_cfg.svh
// Notes:   No constants here
package cupw_pkg;
	typedef enum logic {DIR_UP, DIR_DOWN} cupw_dir_type;
	typedef logic [15:0] cupw_word_type;
endpackage

// ===== rtl/cupw_top.sv
// Purpose: Three compare units with dead-band and output logic driving six PWM pins
// Assumes: APB slave, zero wait states, single 50 MHz clock
// Notes:   Pins 2k and 2k+1 are the upper and lower switch of leg k
// Functional notes
// [R1] Compare each unit against timer, toggle on equality
// [R2] Opposite edge at next match or period end
// [R3] Three units drive three complementary pin pairs
// [R4] Edge-aligned uses continuous up count
// [R5] Four-bit dead-band field reloads each enabled dead timer
// [R6] Action lets partner sit constant while other modulates
// [R7] Compare, action, period writes go through shadows
// [R8] Centre-aligned uses continuous up/down count
// [R9] Centre mode toggles on up and down matches
// [R10] Centre mode loads compare shadow at period match
// [R11] Software order: action, dead-band, compare, control, timer
// [R12] Software enables compare and outputs before use
// [R13] Centre pulses symmetric about period middle
// [R14] Dead time equals field times prescale divisor
// [R15] Action codes: forced low, active low/high, forced high
// [R16] Disable, protect input or reset tri-state all pins
// [R17] Dead-band pair never on together
// [R18] Compare above period leaves output inactive
`timescale 1ns/1ps
`include "cupw_cfg.svh"
module cupw_top (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Power stage
	input  wire logic        I_POWER_DRIVE_PROTECT_N,
	output logic      [5:0]  O_PWM_OUTPUT_PIN,
	output logic      [5:0]  O_PWM_OUTPUT_PIN_OE_N
);
	function automatic logic [8:0] db_len(input logic [3:0] m, input logic [2:0] ps);
		logic [5:0] p;
		p = (ps >= `CUPW_PS_MAX) ? 6'h20 : 6'(6'h01 << ps);
		db_len = 9'(m * p);
	endfunction

	function automatic logic act_pin(input logic [1:0] a, input logic on);
		case (a)
			`CUPW_ACT_FLO: act_pin = 1'b0;
			`CUPW_ACT_ALO: act_pin = ~on;
			`CUPW_ACT_AHI: act_pin = on;
			default:       act_pin = 1'b1;
		endcase
	endfunction

	// Software-visible registers and shadows
	logic [1:0]  mode_q;
	logic [15:0] prd_w_q, prd_s_q, act_w_q, act_s_q, dbctl_q, cmpctl_q, cnt_q;
	logic [15:0] cmp_w_q [3];
	logic [15:0] cmp_s_q [3];
	cupw_pkg::cupw_dir_type dir_q;
	logic [2:0]  ph_q, ph_prev_q;
	logic [8:0]  dcnt_q [3];
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q;
	logic [5:0]  pwm_q, oe_n_q;

	// Bus decode
	wire         wr_en     = I_PSEL & I_PENABLE & I_PWRITE;
	wire         setup     = I_PSEL & ~I_PENABLE;
	wire [15:0]  wdat      = I_PWDATA[15:0];
	wire         hit_tmr   = I_PADDR == `CUPW_OFS_TMRCTL;
	wire         hit_prd   = I_PADDR == `CUPW_OFS_PERIOD;
	wire         hit_c1    = I_PADDR == `CUPW_OFS_CMP1;
	wire         hit_c2    = I_PADDR == `CUPW_OFS_CMP2;
	wire         hit_c3    = I_PADDR == `CUPW_OFS_CMP3;
	wire         hit_act   = I_PADDR == `CUPW_OFS_ACTION;
	wire         hit_db    = I_PADDR == `CUPW_OFS_DBCTL;
	wire         hit_cc    = I_PADDR == `CUPW_OFS_CMPCTL;
	wire         hit_cnt   = I_PADDR == `CUPW_OFS_COUNT;
	wire         hit_st    = I_PADDR == `CUPW_OFS_STATUS;
	wire         mapped    = hit_tmr | hit_prd | hit_c1 | hit_c2 | hit_c3 | hit_act
	                         | hit_db | hit_cc | hit_cnt | hit_st;
	wire [15:0]  status    = {5'h00, dir_q == cupw_pkg::DIR_DOWN, ph_q, ~oe_n_q[0], pwm_q};
	wire [15:0]  rd_mux    = hit_tmr ? {14'h0000, mode_q} :
	                         hit_prd ? prd_w_q : hit_c1 ? cmp_w_q[0] :
	                         hit_c2 ? cmp_w_q[1] : hit_c3 ? cmp_w_q[2] :
	                         hit_act ? act_w_q : hit_db ? dbctl_q :
	                         hit_cc ? cmpctl_q : hit_cnt ? cnt_q :
	                         hit_st ? status : `CUPW_RST16;

	// Timer decode
	wire         run       = mode_q != `CUPW_MODE_STOP;
	wire         updn      = mode_q == `CUPW_MODE_UPDN;
	wire         prd_hit   = run & (cnt_q == prd_s_q);
	wire         reload    = prd_hit | ~run; // [R7] [R10]
	wire         cmp_en    = cmpctl_q[`CUPW_CC_CMP_EN];
	wire         hiz       = ~cmpctl_q[`CUPW_CC_OUT_EN]
	                         | (cmpctl_q[`CUPW_CC_PROT_EN] & ~I_POWER_DRIVE_PROTECT_N); // [R16]
	wire [3:0]   db_m      = dbctl_q[`CUPW_DB_M_HI:`CUPW_DB_M_LO];
	wire [2:0]   db_ps     = dbctl_q[`CUPW_DB_PS_HI:`CUPW_DB_PS_LO];
	wire [8:0]   db_load   = db_len(db_m, db_ps); // [R5] [R14]
	wire [8:0]   db_start  = (db_load == `CUPW_RST9) ? `CUPW_RST9 : 9'(db_load - 9'h001); // [R14]
	wire [2:0]   db_en     = dbctl_q[`CUPW_DB_EN_LO +: 3];
	logic [2:0]  match, ph_d, dt_hi, dt_lo;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			match[i] = cmp_en & run & (cnt_q == cmp_s_q[i]); // [R1] [R18]
			if (!run || !cmp_en)
				ph_d[i] = 1'b0;
			else if (updn && match[i])
				ph_d[i] = dir_q == cupw_pkg::DIR_UP; // [R9] [R13]
			else if (!updn && prd_hit)
				ph_d[i] = 1'b0; // [R2]
			else if (match[i])
				ph_d[i] = 1'b1; // [R1]
			else
				ph_d[i] = ph_q[i];
			dt_hi[i] = ph_q[i] & (~db_en[i] | (ph_q[i] == ph_prev_q[i] && dcnt_q[i] == `CUPW_RST9)); // [R17]
			dt_lo[i] = ~ph_q[i] & (~db_en[i] | (ph_q[i] == ph_prev_q[i] && dcnt_q[i] == `CUPW_RST9)); // [R3] [R17]
		end
	end

	// Registers written by software
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mode_q   <= `CUPW_MODE_STOP;
			prd_w_q  <= `CUPW_RST16;
			act_w_q  <= `CUPW_RST16;
			dbctl_q  <= `CUPW_RST16;
			cmpctl_q <= `CUPW_RST16;
			for (int i = 0; i < 3; i++) cmp_w_q[i] <= `CUPW_RST16;
		end else if (wr_en) begin
			if (hit_tmr) mode_q <= wdat[1:0];
			if (hit_prd) prd_w_q <= wdat;
			if (hit_c1) cmp_w_q[0] <= wdat;
			if (hit_c2) cmp_w_q[1] <= wdat;
			if (hit_c3) cmp_w_q[2] <= wdat;
			if (hit_act) act_w_q <= wdat;
			if (hit_db) dbctl_q <= wdat & `CUPW_DB_MASK;
			if (hit_cc) cmpctl_q <= wdat; // [R12]
		end
	end

	// Shadow reload
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			prd_s_q <= `CUPW_RST16;
			act_s_q <= `CUPW_RST16;
			for (int i = 0; i < 3; i++) cmp_s_q[i] <= `CUPW_RST16;
		end else if (reload) begin
			prd_s_q <= prd_w_q; // [R7]
			act_s_q <= act_w_q; // [R7]
			for (int i = 0; i < 3; i++) cmp_s_q[i] <= cmp_w_q[i]; // [R10]
		end
	end

	// Shared timer
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cnt_q <= `CUPW_RST16;
			dir_q <= cupw_pkg::DIR_UP;
		end else if (!run) begin
			cnt_q <= `CUPW_RST16;
			dir_q <= cupw_pkg::DIR_UP;
		end else if (!updn) begin
			cnt_q <= prd_hit ? `CUPW_RST16 : 16'(cnt_q + 16'h0001); // [R4]
			dir_q <= cupw_pkg::DIR_UP;
		end else if (dir_q == cupw_pkg::DIR_UP) begin
			if (cnt_q >= prd_s_q) begin
				dir_q <= cupw_pkg::DIR_DOWN; // [R8]
				cnt_q <= (cnt_q == `CUPW_RST16) ? cnt_q : 16'(cnt_q - 16'h0001);
			end else
				cnt_q <= 16'(cnt_q + 16'h0001);
		end else if (cnt_q == `CUPW_RST16) begin
			dir_q <= cupw_pkg::DIR_UP;
			cnt_q <= (prd_s_q == `CUPW_RST16) ? cnt_q : 16'h0001;
		end else
			cnt_q <= 16'(cnt_q - 16'h0001);
	end

	// Waveform state and dead-band timers
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ph_q      <= 3'h0;
			ph_prev_q <= 3'h0;
			for (int i = 0; i < 3; i++) dcnt_q[i] <= `CUPW_RST9;
		end else begin
			ph_q      <= ph_d;
			ph_prev_q <= ph_q;
			for (int i = 0; i < 3; i++) begin
				if (ph_q[i] != ph_prev_q[i])
					dcnt_q[i] <= db_en[i] ? db_start : `CUPW_RST9; // [R5] [R14]
				else if (dcnt_q[i] != `CUPW_RST9)
					dcnt_q[i] <= 9'(dcnt_q[i] - 9'h001);
			end
		end
	end

	// Output logic
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pwm_q  <= 6'h00;
			oe_n_q <= 6'h3F; // [R16]
		end else begin
			for (int i = 0; i < 3; i++) begin
				pwm_q[2*i]   <= ~hiz & act_pin(act_s_q[4*i +: 2], dt_hi[i]); // [R6] [R15]
				pwm_q[2*i+1] <= ~hiz & act_pin(act_s_q[4*i+2 +: 2], dt_lo[i]); // [R6] [R15]
			end
			oe_n_q <= {6{hiz}}; // [R16]
		end
	end

	// APB answer, zero wait states
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= 1'b1;
			if (setup) begin
				prdata_q  <= {16'h0000, rd_mux};
				pslverr_q <= ~mapped;
			end
		end
	end

	assign O_PRDATA              = prdata_q;
	assign O_PREADY              = pready_q;
	assign O_PSLVERR             = pslverr_q;
	assign O_PWM_OUTPUT_PIN      = pwm_q;
	assign O_PWM_OUTPUT_PIN_OE_N = oe_n_q;

	// Checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence s_db_edge(i);
		db_en[i] && ph_q[i] != ph_prev_q[i];
	endsequence

	sequence s_up_match(i);
		!updn && match[i] && !prd_hit;
	endsequence

	// Pins and dead-band
	a_pin_hiz_gate: assert property (hiz |=> oe_n_q == 6'h3F && pwm_q == 6'h00) // [R16]
		else $error("pins not released on disable or protect");
	a_prot_trip: assert property (cmpctl_q[`CUPW_CC_PROT_EN] // [R16]
		&& !I_POWER_DRIVE_PROTECT_N |=> oe_n_q == 6'h3F && pwm_q == 6'h00)
		else $error("protect input did not release pins");
	a_pair_no_overlap: assert property (db_en[0] // [R17]
		&& act_s_q[3:0] == {`CUPW_ACT_AHI, `CUPW_ACT_AHI} |=> !(pwm_q[0] && pwm_q[1]))
		else $error("dead-band pair overlap");
	a_db_delay_len: assert property (s_db_edge(0) |=> dcnt_q[0] == $past(db_start)) // [R14]
		else $error("dead-band count wrong");
	a_db_hold_off: assert property (s_db_edge(0) ##1 dcnt_q[0] != `CUPW_RST9 // [R17]
		|-> !dt_hi[0] && !dt_lo[0])
		else $error("pair active during dead time");
	a_action_forced: assert property (!hiz && act_s_q[1:0] == `CUPW_ACT_FHI // [R15]
		&& $stable(act_s_q) |=> pwm_q[0])
		else $error("forced high not driven");
	a_partner_low: assert property (act_s_q[1:0] == `CUPW_ACT_FLO |=> !pwm_q[0]) // [R6]
		else $error("forced low pin went high");
	a_pin_follow: assert property (s_up_match(0) ##1 (!hiz && !db_en[0] // [R1]
		&& act_s_q[1:0] == `CUPW_ACT_AHI) |=> pwm_q[0])
		else $error("pin did not follow compare match");

	// Waveform state
	a_edge_match_set: assert property (!updn && match[0] && !prd_hit |=> ph_q[0]) // [R1]
		else $error("edge mode match did not set output");
	a_edge_period_clr: assert property (run && cmp_en && !updn && prd_hit |=> !ph_q[0]) // [R2]
		else $error("edge mode period end did not clear output");
	a_centre_up_set: assert property (updn && match[0] && dir_q == cupw_pkg::DIR_UP // [R9]
		|=> ph_q[0])
		else $error("centre up match did not set output");
	a_centre_down_clr: assert property (updn && match[2] && dir_q == cupw_pkg::DIR_DOWN // [R9]
		|=> !ph_q[2])
		else $error("centre down match did not clear output");
	a_cmp_off_idle: assert property (!cmp_en |=> ph_q == 3'h0) // [R12]
		else $error("output active with compare disabled");
	a_no_match_above: assert property (run && cmp_s_q[1] > prd_s_q && !reload // [R18]
		|-> !match[1])
		else $error("match beyond period");

	// Timer and shadows
	a_up_step: assert property (!updn && run && !prd_hit // [R4]
		|=> cnt_q == 16'($past(cnt_q) + 16'h0001))
		else $error("up count did not advance");
	a_up_wrap: assert property (!updn && prd_hit |=> cnt_q == `CUPW_RST16) // [R4]
		else $error("up count did not wrap at period");
	a_centre_turn: assert property (updn && dir_q == cupw_pkg::DIR_UP && prd_hit // [R8]
		&& prd_s_q != `CUPW_RST16 |=> dir_q == cupw_pkg::DIR_DOWN)
		else $error("centre count did not turn at period");
	a_centre_floor: assert property (updn && dir_q == cupw_pkg::DIR_DOWN // [R8]
		&& cnt_q == `CUPW_RST16 && prd_s_q != `CUPW_RST16 |=> dir_q == cupw_pkg::DIR_UP)
		else $error("centre count did not turn at zero");
	a_shadow_reload: assert property (prd_hit |=> cmp_s_q[0] == $past(cmp_w_q[0])) // [R10]
		else $error("compare shadow not loaded at period match");
	a_shadow_hold: assert property (run && !prd_hit |=> $stable(cmp_s_q[1]) && $stable(act_s_q)) // [R7]
		else $error("shadow changed mid period");
	a_stop_idle: assert property (!run |=> cnt_q == `CUPW_RST16 && ph_q == 3'h0)
		else $error("timer or outputs active while stopped");

	// Register bus
	a_apb_ready_on: assert property (I_PSEL && I_PENABLE |-> pready_q)
		else $error("ready low in access phase");
	a_bad_addr_err: assert property (setup && !mapped
		|=> pslverr_q && prdata_q == 32'h0000_0000)
		else $error("unmapped address not refused");
	a_prd_write: assert property (wr_en && hit_prd |=> prd_w_q == $past(wdat)) // [R7]
		else $error("period write lost");
endmodule

// ===== bench/cupw_leg_model.sv
// Purpose: Upper and lower switches of three converter legs
// Assumes: Active-high switch gates, pins driven while enable is low
// Notes:   Counts cycles where both switches of one leg conduct
`timescale 1ns/1ps
module cupw_leg_model (
	// Clock
	input  wire logic       i_clk,
	// Gate drive
	input  wire logic [5:0] i_pin,
	input  wire logic [5:0] i_oe_n,
	// Fault count
	output int              o_overlap
);
	logic [5:0] on;
	assign on = i_pin & ~i_oe_n;
	initial o_overlap = 0;
	always @(posedge i_clk) begin
		for (int k = 0; k < 3; k++) begin
			if (on[2*k] === 1'b1 && on[2*k+1] === 1'b1) begin
				o_overlap <= o_overlap + 1;
			end
		end
	end
endmodule

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the compare unit PWM generator
// Assumes: Zero-wait APB slave, period 10 edge mode unless set
// Notes:   Pulse widths are counted over one whole carrier period
`timescale 1ns/1ps
`include "cupw_cfg.svh"
module tb_top;
	logic        I_CLK, I_RST_N, psel, pen, pwr, prot_n, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  pin, oe_n;
	logic        rdy, slverr;
	int          mismatches, cmp_count, ovl, ovl0, cnt[6];
	int          exp_act[4] = '{0, 4, 7, 11};
	cupw_top uut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(rdy), .O_PSLVERR(slverr), .I_POWER_DRIVE_PROTECT_N(prot_n),
		.O_PWM_OUTPUT_PIN(pin), .O_PWM_OUTPUT_PIN_OE_N(oe_n));
	cupw_leg_model legs (.i_clk(I_CLK), .i_pin(pin), .i_oe_n(oe_n), .o_overlap(ovl));
	initial begin
		I_CLK = 0;
		forever #10 I_CLK = ~I_CLK;
	end
	task final_report;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge I_CLK);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge I_CLK);
		pen <= 1;
		i = 0;
		do begin
			@(posedge I_CLK);
			i++;
		end while (rdy !== 1'b1 && i < 50);
		rd = prdata;
		err = slverr;
		psel <= 0;
		pen <= 0;
		if (rdy !== 1'b1) begin
			mismatches++;
			final_report();
		end
	endtask
	task meas(input int n);
		cnt = '{default: 0};
		repeat (n) begin
			@(posedge I_CLK);
			for (int k = 0; k < 6; k++) cnt[k] += (pin[k] === 1'b1 && oe_n[k] === 1'b0);
		end
	endtask
	initial begin
		{psel, pen, pwr, paddr, pwdata, mismatches, cmp_count} = 0;
		I_RST_N = 0;
		prot_n = 1;
		repeat (12) @(posedge I_CLK);
		chk("oe_n", 6'h3F, oe_n);
		chk("pin", 6'h00, pin);
		chk("pready_rst", 0, rdy);
		I_RST_N <= 1;
		apb(0, `CUPW_OFS_ACTION, 0);
		chk("action", 0, rd);
		chk("pready", 1, rdy);
		apb(1, `CUPW_OFS_ACTION, 32'h0AAA);
		apb(1, `CUPW_OFS_PERIOD, 32'hA);
		apb(1, `CUPW_OFS_CMP1, 32'h3);
		apb(1, `CUPW_OFS_CMP2, 32'hC);
		apb(1, `CUPW_OFS_CMP3, 32'h0);
		apb(1, `CUPW_OFS_CMPCTL, 32'h8200);
		apb(1, `CUPW_OFS_TMRCTL, `CUPW_MODE_UP);
		repeat (30) @(posedge I_CLK);
		meas(11);
		chk("up1", 7, cnt[0]);
		chk("lo1", 4, cnt[1]);
		chk("up2", 0, cnt[2]);
		chk("up3", 10, cnt[4]);
		for (int c = 0; c < 4; c++) begin
			apb(1, `CUPW_OFS_ACTION, 32'h0AA8 | c);
			repeat (25) @(posedge I_CLK);
			meas(11);
			chk("act", exp_act[c], cnt[0]);
			chk("partner", 4, cnt[1]);
		end
		apb(1, `CUPW_OFS_ACTION, 32'h0AAA);
		apb(1, `CUPW_OFS_DBCTL, 32'h0124);
		apb(0, `CUPW_OFS_DBCTL, 0);
		chk("dbctl", 32'h0124, rd);
		repeat (30) @(posedge I_CLK);
		ovl0 = ovl;
		meas(11);
		chk("db_up", 5, cnt[0]);
		chk("db_lo", 2, cnt[1]);
		apb(1, `CUPW_OFS_DBCTL, 32'h013C);
		repeat (30) @(posedge I_CLK);
		meas(11);
		chk("db_long_up", 0, cnt[0]);
		chk("db_long_lo", 0, cnt[1]);
		chk("overlap", ovl0, ovl);
		apb(1, `CUPW_OFS_DBCTL, 0);
		apb(1, `CUPW_OFS_TMRCTL, `CUPW_MODE_UPDN);
		repeat (60) @(posedge I_CLK);
		meas(20);
		chk("ctr1", 14, cnt[0]);
		chk("ctr_lo", 6, cnt[1]);
		apb(1, `CUPW_OFS_CMP1, 32'h5);
		repeat (60) @(posedge I_CLK);
		meas(20);
		chk("ctr_new", 10, cnt[0]);
		apb(1, `CUPW_OFS_CMPCTL, 32'h8201);
		prot_n <= 0;
		repeat (4) @(posedge I_CLK);
		chk("trip", 6'h3F, oe_n);
		prot_n <= 1;
		repeat (4) @(posedge I_CLK);
		chk("run", 6'h00, oe_n);
		apb(1, `CUPW_OFS_CMPCTL, 32'h8000);
		repeat (4) @(posedge I_CLK);
		chk("off", 6'h3F, oe_n);
		apb(0, 8'h30, 0);
		chk("slverr", 1, err);
		chk("rd_bad", 0, rd);
		final_report();
	end
endmodule
